// ### tb/dac_house_ctrl_tb.sv
`timescale 1ns/10ps
module dac_house_ctrl_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic reg_wr_i, spi_mode_o;
  logic spi_select_i = 1'b0;
  logic frame_start_i = 1'b0;
  logic serial_flag_pin_i = 1'b0;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [1:0] cable_sense_i = 2'h0;
  logic [7:0] s_pix_i = 8'h00;
  logic [7:0] y_pix_i = 8'h00;
  logic [7:0] c_pix_i = 8'h00;
  logic [4:0] sync_blank_i = 5'h00;
  logic [2:0] dac_low_power_o, dac_power_o, lp;
  logic [7:0] obs_d = 8'h00;
  logic [7:0] rd_d, v;
  logic obs_v = 1'b0;
  logic [7:0] exp_q[$];
  int failures = 0;
  int n_checks = 0;

  always #5 clk_i = ~clk_i;

  host_model host (.clk_i(clk_i), .wr_o(reg_wr_i), .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i), .rdata_i(reg_rdata_o));
  dac_house_ctrl uut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .spi_select_i(spi_select_i), .spi_mode_o(spi_mode_o),
    .frame_start_i(frame_start_i), .cable_sense_i(cable_sense_i),
    .s_pix_i(s_pix_i), .y_pix_i(y_pix_i), .c_pix_i(c_pix_i),
    .sync_blank_i(sync_blank_i), .serial_flag_pin_i(serial_flag_pin_i),
    .dac_low_power_o(dac_low_power_o), .dac_power_o(dac_power_o));

  // --------------------------------
  // Scoreboard
  // --------------------------------
  task automatic note(input logic [7:0] got, input logic [7:0] exp_v);
    exp_q.push_back(exp_v);
    @(posedge clk_i);
    obs_d <= got;
    obs_v <= 1'b1;
    @(posedge clk_i);
    obs_v <= 1'b0;
  endtask

  always @(posedge clk_i) begin
    if (obs_v === 1'b1 && exp_q.size() > 0) begin
      v = exp_q.pop_front();
      n_checks++;
      if (obs_d !== v) begin
        failures++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, obs_d, v);
      end
    end
  end

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp_v);
    host.rd(a, rd_d);
    note(rd_d, exp_v);
  endtask

  // One frame pulse, then the power outputs and the status register
  task automatic frame_chk(input logic [1:0] s, input logic [7:0] ctl,
    input logic [1:0] st, input logic [2:0] pw);
    @(posedge clk_i);
    frame_start_i <= 1'b1;
    cable_sense_i <= s;
    @(posedge clk_i);
    frame_start_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    note({5'h00, dac_power_o}, {5'h00, pw});
    rdchk(dac_house_pkg::CABLE_ADDR, ctl | {6'h00, st});
  endtask

  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    report_and_stop();
  end

  initial begin
    void'($urandom(56));
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    note({5'h00, dac_low_power_o}, 8'h00);
    note({5'h00, dac_power_o}, 8'h07);
    note({7'h00, spi_mode_o}, 8'h00);
    lp = 3'($urandom());
    host.wr(dac_house_pkg::LOW_POWER_ADDR, {5'h00, lp});
    @(posedge clk_i);
    note({5'h00, dac_low_power_o}, {5'h00, lp});
    rdchk(dac_house_pkg::LOW_POWER_ADDR, {5'h00, lp});
    s_pix_i <= 8'($urandom());
    y_pix_i <= 8'($urandom());
    c_pix_i <= 8'($urandom());
    sync_blank_i <= 5'($urandom());
    serial_flag_pin_i <= 1'($urandom());
    repeat (2) @(posedge clk_i);
    rdchk(dac_house_pkg::PIN_RB0_ADDR, s_pix_i);
    rdchk(dac_house_pkg::PIN_RB1_ADDR, y_pix_i);
    rdchk(dac_house_pkg::PIN_RB2_ADDR, c_pix_i);
    rdchk(dac_house_pkg::CTRL_RB_ADDR, {2'h0, serial_flag_pin_i, sync_blank_i});
    rdchk(8'h11, 8'h00);
    // Detection with auto power-down, composite then component
    host.wr(dac_house_pkg::CABLE_ADDR, 8'h14);
    frame_chk(2'b01, 8'h14, 2'b10, 3'b001);
    frame_chk(2'b10, 8'h14, 2'b01, 3'b110);
    host.wr(dac_house_pkg::OUT_CONFIG_ADDR, 8'h01);
    frame_chk(2'b00, 8'h14, 2'b01, 3'b000);
    frame_chk(2'b01, 8'h14, 2'b00, 3'b111);
    host.wr(dac_house_pkg::CABLE_ADDR, 8'h04);
    frame_chk(2'b00, 8'h04, 2'b01, 3'b111);
    host.wr(dac_house_pkg::CABLE_ADDR, 8'h10);
    frame_chk(2'b11, 8'h10, 2'b01, 3'b111);
    host.wr(dac_house_pkg::DAC_POWER_UP_ADDR, 8'h06);
    host.wr(dac_house_pkg::OUT_CONFIG_ADDR, 8'h00);
    host.wr(dac_house_pkg::CABLE_ADDR, 8'h04);
    frame_chk(2'b11, 8'h04, 2'b01, 3'b110);
    // Software reset keeps the selected protocol
    @(posedge clk_i);
    spi_select_i <= 1'b1;
    @(posedge clk_i);
    spi_select_i <= 1'b0;
    host.wr(dac_house_pkg::SOFT_RESET_ADDR, 8'h02);
    repeat (3) @(posedge clk_i);
    rdchk(dac_house_pkg::LOW_POWER_ADDR, 8'h00);
    rdchk(dac_house_pkg::DAC_POWER_UP_ADDR, {5'h00, dac_house_pkg::DAC_POWER_UP_RST});
    rdchk(dac_house_pkg::CABLE_ADDR, 8'h00);
    rdchk(dac_house_pkg::SOFT_RESET_ADDR, 8'h00);
    note({7'h00, spi_mode_o}, 8'h01);
    // Only a power-on reset brings the host port back to its first protocol
    host.wr(dac_house_pkg::LOW_POWER_ADDR, 8'h07);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    note({7'h00, spi_mode_o}, 8'h00);
    note({5'h00, dac_low_power_o}, 8'h00);
    repeat (3) @(posedge clk_i);
    report_and_stop();
  end
endmodule // dac_house_ctrl_tb

// ### tb/host_model.sv
`timescale 1ns/10ps
module host_model (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic wr_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);
  initial begin
    wr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // --------------------------------
  // Host cycles
  // --------------------------------
  // Data is inverted after the strobe so a late capture shows up
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  // Read data is registered, so it is taken two edges after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    repeat (2) @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule // host_model

// ### verilog/cable_status.sv
`timescale 1ns/10ps
module cable_status #(
  parameter int N = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic clear_i,
  // Frame strobe and sensing
  input wire logic frame_i,
  input wire logic [N-1:0] monitor_i,
  input wire logic [N-1:0] sense_i,
  // Status, 0 = cable present
  output logic [N-1:0] status_o
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_dac
      always_ff @(posedge clk_i) begin
        if (clear_i) begin
          status_o[g] <= dac_house_pkg::CABLE_STAT_RST[g];
        end else if (frame_i && monitor_i[g]) begin
          status_o[g] <= ~sense_i[g];
        end
      end
    end
  endgenerate
endmodule // cable_status

// ### verilog/dac_house_ctrl.sv
// Function
// - Three independent DAC low power enables
// - Low power off after any reset
// - Monitor only DACs that are powered up
// - Composite/YC monitors first and second DAC
// - Component monitors first DAC only
// - Status bits updated once per frame
// - Status 0 when cable found, else 1
// - Bit 4 enables automatic DAC power-down
// - Auto power-down needs detection running
// - Composite/YC: DAC1 alone, DAC2 with DAC3
// - Component: first DAC off drops three
// - Power state held for whole frame
// - Host reads back input pin levels
// - Software reset restores register defaults
// - Software reset bit clears itself
// - Software reset keeps host protocol
// - Power-on reset initialises all logic
`timescale 1ns/10ps
module dac_house_ctrl (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register port from the serial host front end
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Host protocol selection
  input wire logic spi_select_i,
  output logic spi_mode_o,
  // Frame timing and cable sensing
  input wire logic frame_start_i,
  input wire logic [1:0] cable_sense_i,
  // Pins for readback
  input wire logic [7:0] s_pix_i,
  input wire logic [7:0] y_pix_i,
  input wire logic [7:0] c_pix_i,
  input wire logic [4:0] sync_blank_i,
  input wire logic serial_flag_pin_i,
  // DAC controls
  output logic [2:0] dac_low_power_o,
  output logic [2:0] dac_power_o
);

  // ------------------------------------------------------------
  // Reset
  // ------------------------------------------------------------
  logic soft_reset_reg;
  logic clear;

  // Register clear comes from power-on or software reset
  assign clear = !rstn_i || soft_reset_reg;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      soft_reset_reg <= 1'b0;
    end else begin
      // Pulse lasts one cycle and then reads back as zero
      soft_reset_reg <= reg_wr_i && reg_addr_i == dac_house_pkg::SOFT_RESET_ADDR
        && reg_wdata_i[dac_house_pkg::SOFT_RESET_BIT] && !soft_reset_reg;
    end
  end

  // Protocol choice survives software reset; only power-on restores it
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      spi_mode_o <= 1'b0;
    end else if (spi_select_i) begin
      spi_mode_o <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic [2:0] power_up_reg;
  logic [2:0] low_power_reg;
  logic component_reg;
  logic detect_en_reg;
  logic auto_pd_reg;
  logic wr_pu;
  logic wr_lp;
  logic wr_cfg;
  logic wr_cab;

  assign wr_pu = reg_wr_i && reg_addr_i == dac_house_pkg::DAC_POWER_UP_ADDR;
  assign wr_lp = reg_wr_i && reg_addr_i == dac_house_pkg::LOW_POWER_ADDR;
  assign wr_cfg = reg_wr_i && reg_addr_i == dac_house_pkg::OUT_CONFIG_ADDR;
  assign wr_cab = reg_wr_i && reg_addr_i == dac_house_pkg::CABLE_ADDR;

  always_ff @(posedge clk_i) begin
    if (clear) begin
      power_up_reg <= dac_house_pkg::DAC_POWER_UP_RST;
    end else if (wr_pu) begin
      power_up_reg <= reg_wdata_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (clear) begin
      low_power_reg <= dac_house_pkg::LOW_POWER_RST;
    end else if (wr_lp) begin
      low_power_reg <= reg_wdata_i[2:0];
    end
  end

  assign dac_low_power_o = low_power_reg;

  always_ff @(posedge clk_i) begin
    if (clear) begin
      component_reg <= dac_house_pkg::CFG_CVBS_YC;
    end else if (wr_cfg) begin
      component_reg <= reg_wdata_i[dac_house_pkg::COMPONENT_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (clear) begin
      detect_en_reg <= 1'b0;
      auto_pd_reg <= 1'b0;
    end else if (wr_cab) begin
      detect_en_reg <= reg_wdata_i[dac_house_pkg::DETECT_EN_BIT];
      auto_pd_reg <= reg_wdata_i[dac_house_pkg::AUTO_PD_BIT];
    end
  end

  // ------------------------------------------------------------
  // Cable detection
  // ------------------------------------------------------------
  logic [1:0] monitor;
  logic [1:0] cable_stat;
  logic [1:0] mon_reg;

  assign monitor[0] = detect_en_reg && power_up_reg[0];
  // Second DAC left alone in component mode so its status stays put
  assign monitor[1] = detect_en_reg && power_up_reg[1]
    && component_reg == dac_house_pkg::CFG_CVBS_YC;

  cable_status #(
    .N(2)
  ) u_cable_status (
    .clk_i(clk_i),
    .clear_i(clear),
    .frame_i(frame_start_i),
    .monitor_i(monitor),
    .sense_i(cable_sense_i),
    .status_o(cable_stat)
  );

  // Which DACs were checked this frame; decisions hold until the next check
  always_ff @(posedge clk_i) begin
    if (clear) begin
      mon_reg <= 2'h0;
    end else if (frame_start_i) begin
      mon_reg <= monitor;
    end
  end

  // ------------------------------------------------------------
  // Auto power-down
  // ------------------------------------------------------------
  logic auto_active;
  logic off1;
  logic off2;
  logic [2:0] power_next;

  // Without detection running the enable bit does nothing
  assign auto_active = auto_pd_reg && detect_en_reg;
  assign off1 = auto_active && mon_reg[0] && cable_stat[0];
  // Component: DAC1 decides for all three; composite: DAC2 decides for 2 and 3
  assign off2 = component_reg ? off1
    : auto_active && mon_reg[1] && cable_stat[1];

  always_comb begin
    power_next = power_up_reg;
    if (off1) begin
      power_next[0] = 1'b0;
    end
    if (off2) begin
      power_next[1] = 1'b0;
      power_next[2] = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clear) begin
      dac_power_o <= dac_house_pkg::DAC_POWER_UP_RST;
    end else begin
      dac_power_o <= power_next;
    end
  end

  // ------------------------------------------------------------
  // Pin readback
  // ------------------------------------------------------------
  logic [29:0] pin_level;

  // Levels are only captured while the pixel clock runs
  pin_sampler #(
    .W(30)
  ) u_pin_sampler (
    .clk_i(clk_i),
    .clear_i(!rstn_i),
    .pins_i({serial_flag_pin_i, sync_blank_i, c_pix_i, y_pix_i, s_pix_i}),
    .level_o(pin_level)
  );

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      case (reg_addr_i)
        dac_house_pkg::DAC_POWER_UP_ADDR: reg_rdata_o <= {5'h00, power_up_reg};
        dac_house_pkg::LOW_POWER_ADDR: reg_rdata_o <= {5'h00, low_power_reg};
        dac_house_pkg::OUT_CONFIG_ADDR: reg_rdata_o <= {7'h00, component_reg};
        dac_house_pkg::CABLE_ADDR: begin
          reg_rdata_o <= {3'h0, auto_pd_reg, 1'b0, detect_en_reg, cable_stat};
        end
        dac_house_pkg::PIN_RB0_ADDR: reg_rdata_o <= pin_level[7:0];
        dac_house_pkg::PIN_RB1_ADDR: reg_rdata_o <= pin_level[15:8];
        dac_house_pkg::PIN_RB2_ADDR: reg_rdata_o <= pin_level[23:16];
        dac_house_pkg::CTRL_RB_ADDR: reg_rdata_o <= {2'h0, pin_level[29:24]};
        dac_house_pkg::SOFT_RESET_ADDR: reg_rdata_o <= {6'h00, soft_reset_reg, 1'b0};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  soft_reset_self_a: assert property (
    soft_reset_reg |=> !soft_reset_reg)
    else $error("software reset bit did not clear");

  low_power_reset_a: assert property (
    soft_reset_reg |=> dac_low_power_o == 3'h0 && !auto_pd_reg)
    else $error("low power or auto power-down survived reset");

  status_update_a: assert property (
    frame_start_i && monitor[0] && !clear |=> cable_stat[0] == !$past(cable_sense_i[0]))
    else $error("first DAC status not updated at frame");

  second_hold_a: assert property (
    component_reg && !clear |=> $stable(cable_stat[1]))
    else $error("unmonitored second DAC status changed");

  auto_off_a: assert property (
    !detect_en_reg && !clear |=> dac_power_o == $past(power_up_reg))
    else $error("auto power-down acted without detection");

  component_off_a: assert property (
    component_reg && off1 && !clear |=> dac_power_o == 3'h0)
    else $error("component mode did not drop all three");

  cvbs_split_a: assert property (
    !component_reg && off1 && !off2 && !clear |=> dac_power_o[2:1] == $past(power_up_reg[2:1]))
    else $error("first DAC loss dropped other DACs");

  spi_kept_a: assert property (
    spi_mode_o && soft_reset_reg |=> spi_mode_o)
    else $error("software reset changed host protocol");

  readback_a: assert property (
    ##2 reg_addr_i == dac_house_pkg::PIN_RB0_ADDR |=> reg_rdata_o == $past(s_pix_i, 2))
    else $error("pixel readback mismatch");

  low_power_write_a: assert property (
    wr_lp && !clear |=> dac_low_power_o == $past(reg_wdata_i[2:0]))
    else $error("low power enables not written");

  power_on_state_a: assert property (
    $rose(rstn_i) |-> dac_power_o == dac_house_pkg::DAC_POWER_UP_RST
      && dac_low_power_o == dac_house_pkg::LOW_POWER_RST
      && !spi_mode_o && reg_rdata_o == 8'h00)
    else $error("outputs not at defaults after power-on reset");

  unpowered_hold_a: assert property (
    frame_start_i && !monitor[0] && !clear |=> $stable(cable_stat[0]))
    else $error("unmonitored first DAC status changed");

  second_status_a: assert property (
    frame_start_i && monitor[1] && !clear |=> cable_stat[1] == !$past(cable_sense_i[1]))
    else $error("second DAC status not updated at frame");

  cvbs_both_a: assert property (
    detect_en_reg && !component_reg && power_up_reg[1:0] == 2'h3 |-> monitor == 2'h3)
    else $error("composite mode did not monitor both DACs");

  component_one_a: assert property (
    component_reg |-> !monitor[1])
    else $error("second DAC monitored in component mode");

  status_quiet_a: assert property (
    !frame_start_i && !clear |=> $stable(cable_stat))
    else $error("status changed between frames");

  auto_disabled_a: assert property (
    !auto_pd_reg && !clear |=> dac_power_o == $past(power_up_reg))
    else $error("power changed with auto power-down off");

  first_off_a: assert property (
    auto_active && mon_reg[0] && cable_stat[0] && !clear |=> !dac_power_o[0])
    else $error("unconnected first DAC stayed powered");

  second_pair_a: assert property (
    !component_reg && auto_active && mon_reg[1] && cable_stat[1] && !clear
      |=> dac_power_o[2:1] == 2'h0)
    else $error("unconnected second DAC left its pair powered");

  first_kept_a: assert property (
    !component_reg && !(mon_reg[0] && cable_stat[0]) && !clear
      |=> dac_power_o[0] == $past(power_up_reg[0]))
    else $error("second DAC loss dropped the first DAC");

  power_hold_a: assert property (
    !frame_start_i && !clear && !wr_pu && !wr_cfg && !wr_cab ##1 !clear
      |=> $stable(dac_power_o))
    else $error("DAC power changed inside a frame");

  soft_restore_a: assert property (
    soft_reset_reg |=> power_up_reg == dac_house_pkg::DAC_POWER_UP_RST && !component_reg
      && !detect_en_reg && cable_stat == dac_house_pkg::CABLE_STAT_RST)
    else $error("register not restored by software reset");

  soft_power_a: assert property (
    soft_reset_reg |=> dac_power_o == dac_house_pkg::DAC_POWER_UP_RST)
    else $error("DAC power not restored by software reset");

  soft_pulse_a: assert property (
    reg_wr_i && reg_addr_i == dac_house_pkg::SOFT_RESET_ADDR
      && reg_wdata_i[dac_house_pkg::SOFT_RESET_BIT] && !soft_reset_reg |=> soft_reset_reg)
    else $error("software reset write did not pulse");

  spi_sticky_a: assert property (
    spi_mode_o |=> spi_mode_o)
    else $error("host protocol left SPI without power-on reset");

  control_readback_a: assert property (
    ##2 reg_addr_i == dac_house_pkg::CTRL_RB_ADDR
      |=> reg_rdata_o == {2'h0, $past(serial_flag_pin_i, 2), $past(sync_blank_i, 2)})
    else $error("control pin readback mismatch");

endmodule // dac_house_ctrl

// ### verilog/dac_house_pkg.sv
package dac_house_pkg;
  // Register offsets
  localparam logic [7:0] DAC_POWER_UP_ADDR = 8'h00;
  localparam logic [7:0] LOW_POWER_ADDR = 8'h0d;
  localparam logic [7:0] OUT_CONFIG_ADDR = 8'h0e;
  localparam logic [7:0] CABLE_ADDR = 8'h10;
  localparam logic [7:0] PIN_RB0_ADDR = 8'h12;
  localparam logic [7:0] PIN_RB1_ADDR = 8'h13;
  localparam logic [7:0] PIN_RB2_ADDR = 8'h14;
  localparam logic [7:0] CTRL_RB_ADDR = 8'h16;
  localparam logic [7:0] SOFT_RESET_ADDR = 8'h17;
  // Field positions
  localparam int STAT_DAC1_BIT = 0;
  localparam int STAT_DAC2_BIT = 1;
  localparam int DETECT_EN_BIT = 2;
  localparam int AUTO_PD_BIT = 4;
  localparam int SOFT_RESET_BIT = 1;
  localparam int COMPONENT_BIT = 0;
  // Values after reset
  localparam logic [2:0] DAC_POWER_UP_RST = 3'h7;
  localparam logic [2:0] LOW_POWER_RST = 3'h0;
  localparam logic [1:0] CABLE_STAT_RST = 2'h0;
  // Output configurations
  typedef enum logic [0:0] {
    CFG_CVBS_YC = 1'b0,
    CFG_COMPONENT = 1'b1
  } out_config_t;
endpackage

// ### verilog/pin_sampler.sv
`timescale 1ns/10ps
module pin_sampler #(
  parameter int W = 30
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic clear_i,
  // Pins
  input wire logic [W-1:0] pins_i,
  output logic [W-1:0] level_o
);
  // Sampled every rising edge of the pixel clock; with no clock the levels freeze
  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      level_o <= '0;
    end else begin
      level_o <= pins_i;
    end
  end
endmodule // pin_sampler
